// >>> idw_pkg.sv
// constants for the interrupt, dma and waveform control register block
package idw_pkg;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h02;
    localparam int CTRL_W = 16;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
    localparam int PORT_B_EN_BIT = 15;
    localparam int PORT_A_EN_BIT = 14;
    localparam int WAVE_SEL_BIT = 13;
    localparam int GIRQ_EN_BIT = 12;
    localparam int GDMA_EN_BIT = 11;
    localparam int TC_IRQ_EN_BIT = 10;
    localparam int ACQ_IRQ_EN_BIT = 9;
    localparam int MODE_HI_BIT = 8;
    localparam int MODE_LO_BIT = 6;
    localparam int HALF_REQ_BIT = 5;
    localparam int RETRIGGER_HOLD_HOLD_BIT = 4;
    localparam int LINE4_RCV_BIT = 3;
    localparam int LINE4_DRV_BIT = 2;
    localparam int LINE2_RCV_BIT = 1;
    localparam int LINE2_DRV_BIT = 0;
    localparam int DIO_W = 4;
    localparam int MODE_W = 3;
    localparam logic [MODE_W-1:0] MODE_NONE = 3'h0;
    localparam int SYNC_W = 7;
    // idle level of each synchronised pin, so no false edge follows reset
    localparam logic [SYNC_W-1:0] SYNC_INIT = 7'h6e;
endpackage : idw_pkg

// >>> idw_sync.sv
// two-flop synchronisers for asynchronous pin inputs
`timescale 1ns/100ps
module idw_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_reg <= INIT;
            sync_o <= INIT;
        end else if (clk_en_i) begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule : idw_sync

// >>> idw_ctrl.sv
// write-only interrupt, dma and waveform control register with its gating
`timescale 1ns/100ps
module idw_ctrl (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [idw_pkg::ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [idw_pkg::CTRL_W-1:0] wdata_i,
    output logic [idw_pkg::CTRL_W-1:0] rdata_o,
    output logic rdata_oe_o,
    input wire logic [idw_pkg::DIO_W-1:0] port_a_data_i,
    input wire logic [idw_pkg::DIO_W-1:0] port_b_data_i,
    output logic [idw_pkg::DIO_W-1:0] port_a_o,
    output logic port_a_oe_o,
    output logic [idw_pkg::DIO_W-1:0] port_b_o,
    output logic port_b_oe_o,
    input wire logic converter_write_i,
    input wire logic update_reg_strobe_i,
    input wire logic [1:0] update_source_sel_i,
    input wire logic counter1_output_i,
    input wire logic counter2_output_i,
    input wire logic counter5_output_i,
    input wire logic external_converter_update_n_i,
    input wire logic bus_line4_i,
    output logic bus_line4_o,
    output logic bus_line4_oe_o,
    input wire logic bus_line2_i,
    output logic bus_line2_o,
    output logic bus_line2_oe_o,
    output logic counter1_gate_o,
    output logic counter1_gate_oe_o,
    output logic converter_update_o,
    input wire logic terminal_count_i,
    input wire logic terminal_count_irq_clear_i,
    input wire logic acq_clear_strobe_i,
    input wire logic acq_done_i,
    input wire logic fifo_overrun_i,
    input wire logic fifo_overflow_i,
    input wire logic fifo_not_empty_i,
    input wire logic fifo_half_full_i,
    input wire logic [idw_pkg::MODE_W-1:0] irq_mode_mask_i,
    input wire logic [idw_pkg::MODE_W-1:0] dma_mode_mask_i,
    input wire logic fifo_irq_enable_i,
    input wire logic fifo_dma_enable_i,
    input wire logic acq_trigger_i,
    output logic irq_o,
    output logic dma_req_o,
    output logic acq_start_o,
    output logic acq_complete_status_o,
    output logic [idw_pkg::MODE_W-1:0] xfer_mode_o
);
    import idw_pkg::*;

    logic [CTRL_W-1:0] ctrl_reg;
    logic [SYNC_W-1:0] pins_sync;
    logic update_trig_n_reg;
    logic tc_pend_reg;
    logic acq_pend_reg;
    logic fifo_req_reg;

    // every pin input passes the two-flop synchroniser before use
    idw_sync #(.WIDTH(SYNC_W), .INIT(SYNC_INIT)) u_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .async_i({external_converter_update_n_i, bus_line4_i, bus_line2_i, counter1_output_i,
                  counter2_output_i, counter5_output_i, terminal_count_i}),
        .sync_o(pins_sync)
    );
    logic ext_upd_n_s, line4_s, line2_s, cnt1_s, cnt2_s, cnt5_s, tc_s;
    assign {ext_upd_n_s, line4_s, line2_s, cnt1_s, cnt2_s, cnt5_s, tc_s} = pins_sync;

    function automatic logic bit_of(input logic [CTRL_W-1:0] r, input int idx);
        return r[idx];
    endfunction : bit_of

    wire ctrl_hit = addr_i == CTRL_OFS;
    wire [MODE_W-1:0] mode = ctrl_reg[MODE_HI_BIT:MODE_LO_BIT];

    // register writes
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (clk_en_i && wr_i && ctrl_hit) begin
            ctrl_reg <= wdata_i;
        end
    end

    // write-only: a read of this offset never drives the data bus
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
            rdata_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            rdata_o <= '0;
            rdata_oe_o <= 1'b0;
        end
    end

    // digital ports and trigger bus drivers
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_a_o <= '0;
            port_a_oe_o <= 1'b0;
            port_b_o <= '0;
            port_b_oe_o <= 1'b0;
            bus_line4_o <= 1'b0;
            bus_line4_oe_o <= 1'b0;
            bus_line2_o <= 1'b0;
            bus_line2_oe_o <= 1'b0;
            counter1_gate_o <= 1'b0;
            counter1_gate_oe_o <= 1'b0;
            xfer_mode_o <= MODE_NONE;
        end else if (clk_en_i) begin
            port_a_o <= port_a_data_i;
            port_a_oe_o <= bit_of(ctrl_reg, PORT_A_EN_BIT);
            port_b_o <= port_b_data_i;
            port_b_oe_o <= bit_of(ctrl_reg, PORT_B_EN_BIT);
            bus_line4_o <= cnt5_s;
            bus_line4_oe_o <= bit_of(ctrl_reg, LINE4_DRV_BIT);
            bus_line2_o <= cnt2_s;
            bus_line2_oe_o <= bit_of(ctrl_reg, LINE2_DRV_BIT);
            counter1_gate_o <= line2_s;
            counter1_gate_oe_o <= bit_of(ctrl_reg, LINE2_RCV_BIT);
            xfer_mode_o <= mode;
        end
    end

    // update trigger source: routing bit chooses the external path, a select picks a counter
    logic trig_n;
    always_comb begin
        unique case (update_source_sel_i)
            2'h0: trig_n = bit_of(ctrl_reg, LINE4_RCV_BIT) ? line4_s : ext_upd_n_s;
            2'h1: trig_n = cnt1_s;
            2'h2: trig_n = cnt2_s;
            2'h3: trig_n = cnt5_s;
        endcase
    end

    // falling edge of the active-low trigger marks the pulse
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            update_trig_n_reg <= 1'b1;
            converter_update_o <= 1'b0;
        end else if (clk_en_i) begin
            update_trig_n_reg <= trig_n;
            if (bit_of(ctrl_reg, WAVE_SEL_BIT)) begin
                converter_update_o <= (update_trig_n_reg && !trig_n) || update_reg_strobe_i;
            end else begin
                converter_update_o <= converter_write_i;
            end
        end
    end

    // pending interrupt flags; a set in the clear cycle wins
    logic tc_prev_reg;
    wire tc_event = tc_s && !tc_prev_reg && bit_of(ctrl_reg, TC_IRQ_EN_BIT);
    wire acq_event = (acq_done_i || fifo_overrun_i || fifo_overflow_i)
        && bit_of(ctrl_reg, ACQ_IRQ_EN_BIT);
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tc_prev_reg <= 1'b0;
            tc_pend_reg <= 1'b0;
            acq_pend_reg <= 1'b0;
            acq_complete_status_o <= 1'b0;
        end else if (clk_en_i) begin
            tc_prev_reg <= tc_s;
            if (tc_event) tc_pend_reg <= 1'b1;
            else if (terminal_count_irq_clear_i) tc_pend_reg <= 1'b0;
            if (acq_event) acq_pend_reg <= 1'b1;
            else if (acq_clear_strobe_i) acq_pend_reg <= 1'b0;
            if (acq_done_i || fifo_overrun_i || fifo_overflow_i) acq_complete_status_o <= 1'b1;
            else if (acq_clear_strobe_i) acq_complete_status_o <= 1'b0;
        end
    end

    // fifo request level: follows half-full with bit 5 set, otherwise not-empty
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fifo_req_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (bit_of(ctrl_reg, HALF_REQ_BIT)) fifo_req_reg <= fifo_half_full_i;
            else if (fifo_half_full_i) fifo_req_reg <= 1'b1;
            else if (!fifo_not_empty_i) fifo_req_reg <= 1'b0;
            else if (!fifo_req_reg) fifo_req_reg <= 1'b1;
        end
    end

    // mode masks say which transfer types this mode field enables
    wire mode_irq = (mode != MODE_NONE) && |(mode & irq_mode_mask_i);
    wire mode_dma = |(mode & dma_mode_mask_i);
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
            dma_req_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_o <= tc_pend_reg || acq_pend_reg
                || (mode_irq && fifo_req_reg && (bit_of(ctrl_reg, GIRQ_EN_BIT) || fifo_irq_enable_i));
            dma_req_o <= bit_of(ctrl_reg, GDMA_EN_BIT) && fifo_dma_enable_i
                && mode_dma && fifo_req_reg;
        end
    end

    // retrigger gate
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acq_start_o <= 1'b0;
        end else if (clk_en_i) begin
            acq_start_o <= acq_trigger_i
                && !(bit_of(ctrl_reg, RETRIGGER_HOLD_HOLD_BIT) && acq_complete_status_o);
        end
    end

    AST_DMA_OFF: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        clk_en_i && !ctrl_reg[GDMA_EN_BIT] |=> !dma_req_o) else $error("dma request while disabled");
    AST_PORT_A: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        clk_en_i |=> port_a_oe_o == $past(ctrl_reg[PORT_A_EN_BIT])) else $error("port a enable wrong");
    AST_PORT_B: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        clk_en_i |=> port_b_oe_o == $past(ctrl_reg[PORT_B_EN_BIT])) else $error("port b enable wrong");
    AST_IMM_UPD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        clk_en_i && !ctrl_reg[WAVE_SEL_BIT] && converter_write_i |=> converter_update_o)
        else $error("immediate update missed");
    AST_TC_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        clk_en_i && tc_event |=> tc_pend_reg ##1 (irq_o || !clk_en_i)) else $error("terminal count lost");
    AST_TC_CLR: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        clk_en_i && terminal_count_irq_clear_i && !tc_event |=> !tc_pend_reg) else $error("tc clear failed");
    AST_ACQ_CLR: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        clk_en_i && acq_clear_strobe_i && !acq_event |=> !acq_pend_reg) else $error("acq clear failed");
    AST_RETRIGGER_HOLD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        clk_en_i && ctrl_reg[RETRIGGER_HOLD_HOLD_BIT] && acq_complete_status_o |=> !acq_start_o)
        else $error("retrigger not held");
    AST_WRITE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        clk_en_i && wr_i && ctrl_hit |=> ctrl_reg == $past(wdata_i)) else $error("write lost");
endmodule : idw_ctrl

// >>> idw_host_model.sv
// host processor and dma controller model: terminal count pin and service writes
`timescale 1ns/100ps
module idw_host_model (
    input wire logic clock_i,
    input wire logic tc_req_i,
    input wire logic svc_req_i,
    output logic terminal_count_o,
    output logic tc_clear_o
);
    // small transfer count so the wrap comes two cycles into a request
    logic [15:0] count_reg;
    initial begin
        count_reg = 16'h0001;
        terminal_count_o = 1'b0;
        tc_clear_o = 1'b0;
    end
    // posedge with non-blocking outputs: no race with the bench's falling-edge stimulus
    always @(posedge clock_i) begin
        tc_clear_o <= svc_req_i;
        terminal_count_o <= tc_req_i && (count_reg == 16'h0000);
        if (tc_req_i) begin
            count_reg <= count_reg - 16'h0001;
        end else begin
            count_reg <= 16'h0001;
        end
    end
endmodule : idw_host_model

// >>> idw_ctrl_test.sv
// self-checking bench for the control register block
`timescale 1ns/100ps
module idw_ctrl_test;
    import idw_pkg::*;
    logic clock_i, sys_rst_i, clk_en_i, wr_i, rd_i, converter_write_i, update_reg_strobe_i, counter1_output_i;
    logic counter2_output_i, counter5_output_i, external_converter_update_n_i, bus_line4_i, bus_line2_i;
    logic terminal_count_i, terminal_count_irq_clear_i, acq_clear_strobe_i, acq_done_i, fifo_overrun_i;
    logic fifo_overflow_i, fifo_not_empty_i, fifo_half_full_i, fifo_irq_enable_i, fifo_dma_enable_i, acq_trigger_i;
    logic [ADDR_W-1:0] addr_i;
    logic [CTRL_W-1:0] wdata_i, rdata_o;
    logic [DIO_W-1:0] port_a_data_i, port_b_data_i, port_a_o, port_b_o;
    logic [1:0] update_source_sel_i;
    logic [MODE_W-1:0] irq_mode_mask_i, dma_mode_mask_i, xfer_mode_o;
    logic rdata_oe_o, port_a_oe_o, port_b_oe_o, bus_line4_o, bus_line4_oe_o, bus_line2_o, bus_line2_oe_o;
    logic counter1_gate_o, counter1_gate_oe_o, converter_update_o, irq_o, dma_req_o, acq_start_o;
    logic acq_complete_status_o, tc_req, svc_req, seen;
    int n_mismatch = 0;
    int total_checks = 0;

    idw_ctrl uut (.*);
    idw_host_model host (.clock_i(clock_i), .tc_req_i(tc_req), .svc_req_i(svc_req),
        .terminal_count_o(terminal_count_i), .tc_clear_o(terminal_count_irq_clear_i));

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chkb

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask : cyc

    // one-cycle pulse, entered and left at a falling edge
    task automatic pul(ref logic s);
        s = 1'b1;
        @(negedge clock_i);
        s = 1'b0;
    endtask : pul

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [CTRL_W-1:0] d);
        @(negedge clock_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge clock_i);
        wr_i = 1'b0;
        cyc(3);
    endtask : wr

    initial begin
        #75000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        {wr_i, rd_i, converter_write_i, update_reg_strobe_i, bus_line2_i, acq_clear_strobe_i, acq_done_i} = '0;
        {fifo_overrun_i, fifo_overflow_i, fifo_not_empty_i, fifo_half_full_i, fifo_irq_enable_i} = '0;
        {fifo_dma_enable_i, acq_trigger_i, tc_req, svc_req, addr_i, wdata_i, update_source_sel_i} = '0;
        {irq_mode_mask_i, dma_mode_mask_i} = '0;
        {counter1_output_i, counter2_output_i, counter5_output_i, external_converter_update_n_i} = 4'hf;
        bus_line4_i = 1'b1;
        port_a_data_i = 4'h5;
        port_b_data_i = 4'ha;
        sys_rst_i = 1'b1;
        clk_en_i = 1'b1;
        cyc(10);
        sys_rst_i = 1'b0;
        cyc(1);
        chk(16'({port_b_oe_o, port_a_oe_o, irq_o, dma_req_o, bus_line4_oe_o, bus_line2_oe_o, xfer_mode_o}), 16'h0000);
        $display("reset test done");
        wr(CTRL_OFS, 16'h8000);
        chk({port_b_oe_o, port_a_oe_o, 6'h00, port_b_o, port_a_o}, 16'h80a5);
        wr(5'h03, 16'h4000);
        rd_i = 1'b1;
        cyc(2);
        rd_i = 1'b0;
        chk(16'({rdata_oe_o, port_b_oe_o, port_a_oe_o}), 16'h0002);
        chk(rdata_o, 16'h0000);
        wr(CTRL_OFS, 16'h4000);
        chk(16'({port_b_oe_o, port_a_oe_o}), 16'h0001);
        for (int m = 0; m < 8; m++) begin
            wr(CTRL_OFS, {7'h00, 3'(m), 6'(m[0] ? 6'h05 : 6'h0a)});
            chk(16'(xfer_mode_o), 16'(m));
            chk(16'({bus_line4_oe_o, counter1_gate_oe_o, bus_line2_oe_o}), m[0] ? 16'h0005 : 16'h0002);
        end
        {counter5_output_i, counter2_output_i, bus_line2_i} = 3'b001;
        cyc(4);
        chk(16'({bus_line4_o, bus_line2_o, counter1_gate_o}), 16'h0001);
        {counter5_output_i, counter2_output_i, bus_line2_i} = 3'b110;
        $display("register test done");
        wr(CTRL_OFS, 16'h0000);
        pul(converter_write_i);
        chkb(converter_update_o, 1'b1);
        wr(CTRL_OFS, 16'h2000);
        pul(converter_write_i);
        chkb(converter_update_o, 1'b0);
        pul(update_reg_strobe_i);
        chkb(converter_update_o, 1'b1);
        // one source per pass: external pin, then counters 1, 2 and 5
        for (int s = 0; s < 4; s++) begin
            update_source_sel_i = 2'(s);
            seen = 1'b0;
            cyc(4);
            {counter5_output_i, counter2_output_i, counter1_output_i, external_converter_update_n_i} = ~(4'h1 << s);
            repeat (8) begin
                @(negedge clock_i);
                seen = seen | converter_update_o;
            end
            chkb(seen, 1'b1);
            {counter5_output_i, counter2_output_i, counter1_output_i, external_converter_update_n_i} = 4'hf;
        end
        // routed path with the bus line receive bit set
        wr(CTRL_OFS, 16'h2008);
        update_source_sel_i = 2'h0;
        seen = 1'b0;
        bus_line4_i = 1'b0;
        repeat (8) begin
            @(negedge clock_i);
            seen = seen | converter_update_o;
        end
        chkb(seen, 1'b1);
        bus_line4_i = 1'b1;
        $display("converter test done");
        wr(CTRL_OFS, 16'h0400);
        tc_req = 1'b1;
        cyc(3);
        tc_req = 1'b0;
        cyc(6);
        chkb(irq_o, 1'b1);
        pul(svc_req);
        cyc(4);
        chkb(irq_o, 1'b0);
        wr(CTRL_OFS, 16'h0000);
        tc_req = 1'b1;
        cyc(3);
        tc_req = 1'b0;
        cyc(6);
        chkb(irq_o, 1'b0);
        wr(CTRL_OFS, 16'h0200);
        pul(acq_done_i);
        cyc(3);
        chk(16'({irq_o, acq_complete_status_o}), 16'h0003);
        pul(acq_clear_strobe_i);
        cyc(3);
        chk(16'({irq_o, acq_complete_status_o}), 16'h0000);
        pul(fifo_overrun_i);
        cyc(3);
        chkb(irq_o, 1'b1);
        pul(acq_clear_strobe_i);
        wr(CTRL_OFS, 16'h0010);
        pul(fifo_overflow_i);
        cyc(2);
        pul(acq_trigger_i);
        seen = 1'b0;
        repeat (4) begin
            @(negedge clock_i);
            seen = seen | acq_start_o;
        end
        chk(16'({seen, acq_complete_status_o}), 16'h0001);
        wr(CTRL_OFS, 16'h0000);
        pul(acq_trigger_i);
        chkb(acq_start_o, 1'b1);
        $display("interrupt test done");
        {fifo_half_full_i, fifo_not_empty_i, fifo_dma_enable_i, dma_mode_mask_i} = 6'h3f;
        wr(CTRL_OFS, 16'h0060);
        chkb(dma_req_o, 1'b0);
        wr(CTRL_OFS, 16'h0860);
        chkb(dma_req_o, 1'b1);
        fifo_dma_enable_i = 1'b0;
        cyc(3);
        chkb(dma_req_o, 1'b0);
        irq_mode_mask_i = 3'h7;
        cyc(3);
        chkb(irq_o, 1'b0);
        fifo_irq_enable_i = 1'b1;
        cyc(3);
        chkb(irq_o, 1'b1);
        fifo_irq_enable_i = 1'b0;
        wr(CTRL_OFS, 16'h1060);
        chkb(irq_o, 1'b1);
        wr(CTRL_OFS, 16'h1020);
        chkb(irq_o, 1'b0);
        // one-sample request level with bit 5 clear
        {fifo_dma_enable_i, fifo_half_full_i} = 2'b10;
        wr(CTRL_OFS, 16'h0840);
        chkb(dma_req_o, 1'b1);
        fifo_not_empty_i = 1'b0;
        cyc(3);
        chkb(dma_req_o, 1'b0);
        $display("dma test done");
        stop_test();
    end
endmodule : idw_ctrl_test
